// >>> rtl/alu_pkg.sv
// Purpose: shared constants for the subtract, multiply, divide and compare datapath
// Assumes: 16-bit words, bit 0 of the instruction is the most significant bit
// Notes: execution times are in nanoseconds and turn into cycle counts at 100 MHz
package alu_pkg;
    // ----------------------------------------------------------------
    // word and clock
    // ----------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [15:0] MOST_NEGATIVE = 16'h8000;
    localparam logic [15:0] SIGN_MASK = 16'h8000;
    localparam logic [15:0] PC_STEP_2 = 16'h0002;
    localparam logic [15:0] PC_STEP_3 = 16'h0003;
    localparam logic [15:0] PC_STEP_4 = 16'h0004;

    // ----------------------------------------------------------------
    // operation codes handed in by the sequencer
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        subtract_short_displaced = 4'h0,
        subtract_short_indexed = 4'h1,
        subtract_reg_reg = 4'h2,
        subtract_reg_reg_branch = 4'h3,
        multiply_short_displaced = 4'h4,
        multiply_reg_reg = 4'h5,
        divide_short_indexed = 4'h6,
        divide_reg_reg = 4'h7,
        compare_long_branch = 4'h8,
        compare_displaced_branch = 4'h9,
        compare_indexed_branch = 4'ha,
        move_and_clear_overflow = 4'hb,
        negate_reg_reg = 4'hc,
        negate_reg_reg_branch = 4'hd
    } op_e;

    // ----------------------------------------------------------------
    // instruction encodings (top two nibbles)
    // ----------------------------------------------------------------
    localparam logic [7:0] ENC_SUB_INDEXED = 8'hf9;
    localparam logic [7:0] ENC_SUB_REG = 8'h69;
    localparam logic [7:0] ENC_MUL_DISPLACED = 8'hb0;
    localparam logic [7:0] ENC_MUL_REG = 8'h20;
    localparam logic [7:0] ENC_DIV_INDEXED = 8'hb9;
    localparam logic [7:0] ENC_CMP_LONG = 8'hc7;

    // ----------------------------------------------------------------
    // execution times in ns
    // ----------------------------------------------------------------
    localparam int T_SUB_SHORT_NS = 1870;
    localparam int T_SUB_REG_NS = 800;
    localparam int T_SUB_BRANCH_NS = 1600;
    localparam int T_MUL_REG_NS = 6670;
    localparam int T_MUL_DISP_NS = 7210;
    localparam int T_DIV_INDEXED_NS = 11400;
    localparam int T_DIV_REG_NS = 11000;
    localparam int T_CMP_LONG_NS = 4530;
    localparam int T_CMP_SHORT_NS = 4000;
    localparam int T_MOVE_OVF_NS = 800;
    localparam int T_NEG_NS = 800;
    localparam int T_NEG_BRANCH_NS = 1600;
endpackage

// >>> rtl/alu_div_unit.sv
// Purpose: signed 32 by 16 divide with quotient overflow detection
// Assumes: operands stable while i_start is seen
// Notes: combinational; the caller registers the results
`timescale 1ns/10ps
module alu_div_unit
(
    input wire logic [31:0] i_dividend,
    input wire logic [15:0] i_divisor,
    output logic [15:0] o_quotient,
    output logic [15:0] o_remainder,
    output logic o_overflow
);
    logic [31:0] mag_dividend;
    logic [15:0] mag_divisor;
    logic [31:0] mag_quot;
    logic [15:0] mag_rem;
    logic [16:0] shifted_high;
    logic q_neg;

    // ----------------------------------------------------------------
    // magnitude divide and sign restore
    // ----------------------------------------------------------------
    always_comb
    begin
        mag_dividend = i_dividend[31] ? 32'(-i_dividend) : i_dividend;
        mag_divisor = i_divisor[15] ? 16'(-i_divisor) : i_divisor;
        q_neg = i_dividend[31] ^ i_divisor[15];
        if (mag_divisor == 16'h0000)
        begin
            mag_quot = 32'h0000_0000;
            mag_rem = 16'h0000;
        end
        else
        begin
            mag_quot = mag_dividend / {16'h0000, mag_divisor};
            mag_rem = 16'(mag_dividend % {16'h0000, mag_divisor});
        end
        o_quotient = q_neg ? 16'(-mag_quot) : mag_quot[15:0];
        o_quotient[15] = q_neg;
        o_remainder = i_dividend[31] ? 16'(-mag_rem) : mag_rem;
    end

    // ----------------------------------------------------------------
    // overflow: sign versus next bit, then shifted high half magnitude
    // ----------------------------------------------------------------
    always_comb
    begin
        shifted_high = mag_dividend[31:15];
        o_overflow = (i_dividend[31] != i_dividend[30])
            || (shifted_high >= {1'b0, mag_divisor});
    end
endmodule

// >>> rtl/alu_exec.sv
// Purpose: execution datapath for subtract, multiply, divide, compare and negate
// Assumes: sequencer supplies operands, accepts a one-cycle done with results
// Notes: operation time is modelled by a busy countdown per instruction
`timescale 1ns/10ps

module alu_exec
#(
    parameter int CLK_NS = alu_pkg::CLK_PERIOD_NS
)
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_start,
    input wire logic [3:0] i_op,
    input wire logic [15:0] i_instr,
    input wire logic [15:0] i_acc,
    input wire logic [15:0] i_partner,
    input wire logic [15:0] i_second,
    input wire logic [15:0] i_mem,
    input wire logic [15:0] i_pc,
    input wire logic [15:0] i_ea,
    input wire logic [15:0] i_word2,
    input wire logic [15:0] i_word3,
    input wire logic [15:0] i_word4,
    input wire logic i_carry_in,
    input wire logic i_carry_valid,
    output logic o_busy,
    output logic o_done,
    output logic o_acc_we,
    output logic [3:0] o_acc_addr,
    output logic [15:0] o_acc_data,
    output logic o_partner_we,
    output logic [3:0] o_partner_addr,
    output logic [15:0] o_partner_data,
    output logic o_pc_we,
    output logic [15:0] o_pc,
    output logic o_overflow,
    output logic o_carry_save,
    output logic o_illegal
);
    // ----------------------------------------------------------------
    // cycle counts derived from documented times, rounded up
    // ----------------------------------------------------------------
    localparam int C_SUB_SHORT = (alu_pkg::T_SUB_SHORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_SUB_REG = (alu_pkg::T_SUB_REG_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_SUB_BRANCH = (alu_pkg::T_SUB_BRANCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_MUL_REG = (alu_pkg::T_MUL_REG_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_MUL_DISP = (alu_pkg::T_MUL_DISP_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_DIV_IDX = (alu_pkg::T_DIV_INDEXED_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_DIV_REG = (alu_pkg::T_DIV_REG_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_CMP_LONG = (alu_pkg::T_CMP_LONG_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_CMP_SHORT = (alu_pkg::T_CMP_SHORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_MOVE_OVF = (alu_pkg::T_MOVE_OVF_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_NEG = (alu_pkg::T_NEG_NS + CLK_NS - 1) / CLK_NS;
    localparam int C_NEG_BRANCH = (alu_pkg::T_NEG_BRANCH_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_run = 2'b01,
        st_done = 2'b11
    } state_e;

    state_e state;
    logic [11:0] count;
    logic [3:0] op;
    logic [3:0] acc_addr;
    logic [15:0] acc_v;
    logic [15:0] partner_v;
    logic [15:0] operand;
    logic [15:0] pc_v;
    logic [15:0] ea_v;
    logic [15:0] w2;
    logic [15:0] w3;
    logic [15:0] w4;
    logic [16:0] diff_full;
    logic [15:0] diff;
    logic sub_ovf;
    logic [31:0] product;
    logic [15:0] neg;
    logic [15:0] div_quot;
    logic [15:0] div_rem;
    logic div_ovf;
    logic [11:0] next_count;
    logic encoding_ok;

    // ----------------------------------------------------------------
    // shared arithmetic
    // ----------------------------------------------------------------
    assign diff_full = {1'b0, acc_v} - {1'b0, operand};
    assign diff = diff_full[15:0];
    assign sub_ovf = (diff[15] == operand[15]) && (diff[15] != acc_v[15]);
    assign product = 32'($signed(operand) * $signed(partner_v));
    assign neg = 16'(~operand + 16'h0001);

    alu_div_unit u_div
    (
        .i_dividend({acc_v, partner_v}),
        .i_divisor(operand),
        .o_quotient(div_quot),
        .o_remainder(div_rem),
        .o_overflow(div_ovf)
    );

    // ----------------------------------------------------------------
    // execution length per operation
    // ----------------------------------------------------------------
    always_comb
    begin
        case (alu_pkg::op_e'(i_op))
            alu_pkg::subtract_short_displaced: next_count = 12'(C_SUB_SHORT);
            alu_pkg::subtract_short_indexed: next_count = 12'(C_SUB_SHORT);
            alu_pkg::subtract_reg_reg: next_count = 12'(C_SUB_REG);
            alu_pkg::subtract_reg_reg_branch: next_count = 12'(C_SUB_BRANCH);
            alu_pkg::multiply_short_displaced: next_count = 12'(C_MUL_DISP);
            alu_pkg::multiply_reg_reg: next_count = 12'(C_MUL_REG);
            alu_pkg::divide_short_indexed: next_count = 12'(C_DIV_IDX);
            alu_pkg::divide_reg_reg: next_count = 12'(C_DIV_REG);
            alu_pkg::compare_long_branch: next_count = 12'(C_CMP_LONG);
            alu_pkg::compare_displaced_branch: next_count = 12'(C_CMP_SHORT);
            alu_pkg::compare_indexed_branch: next_count = 12'(C_CMP_SHORT);
            alu_pkg::move_and_clear_overflow: next_count = 12'(C_MOVE_OVF);
            alu_pkg::negate_reg_reg: next_count = 12'(C_NEG);
            alu_pkg::negate_reg_reg_branch: next_count = 12'(C_NEG_BRANCH);
            default: next_count = 12'h001;
        endcase
    end

    // ----------------------------------------------------------------
    // encoding check for the documented fixed-field forms
    // ----------------------------------------------------------------
    always_comb
    begin
        case (alu_pkg::op_e'(i_op))
            alu_pkg::subtract_short_indexed: encoding_ok = i_instr[15:8] == alu_pkg::ENC_SUB_INDEXED;
            alu_pkg::subtract_reg_reg: encoding_ok = i_instr[15:8] == alu_pkg::ENC_SUB_REG;
            alu_pkg::multiply_short_displaced: encoding_ok = i_instr[15:8] == alu_pkg::ENC_MUL_DISPLACED;
            alu_pkg::multiply_reg_reg: encoding_ok = i_instr[15:8] == alu_pkg::ENC_MUL_REG;
            alu_pkg::divide_short_indexed: encoding_ok = i_instr[15:8] == alu_pkg::ENC_DIV_INDEXED;
            alu_pkg::compare_long_branch: encoding_ok = i_instr[15:8] == alu_pkg::ENC_CMP_LONG;
            default: encoding_ok = 1'b1;
        endcase
    end

    // ----------------------------------------------------------------
    // sequencing: capture, count down, report done for one cycle
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state <= st_idle;
            count <= 12'h000;
        end
        else
        begin
            case (state)
                st_idle:
                begin
                    if (i_start)
                    begin
                        state <= st_run;
                        count <= next_count;
                    end
                end
                st_run:
                begin
                    if (count <= 12'h001)
                        state <= st_done;
                    else
                        count <= count - 12'h001;
                end
                st_done: state <= st_idle;
                default: state <= st_idle;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // operand capture at start
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            op <= 4'h0;
            acc_addr <= 4'h0;
            acc_v <= 16'h0000;
            partner_v <= 16'h0000;
            operand <= 16'h0000;
            pc_v <= 16'h0000;
            ea_v <= 16'h0000;
            w2 <= 16'h0000;
            w3 <= 16'h0000;
            w4 <= 16'h0000;
            o_illegal <= 1'b0;
        end
        else if (state == st_idle && i_start)
        begin
            op <= i_op;
            acc_addr <= i_instr[7:4]; // bits 8-11, msb-first numbering
            acc_v <= i_acc;
            partner_v <= i_partner;
            // memory forms use the fetched word, register forms the second register
            case (alu_pkg::op_e'(i_op))
                alu_pkg::subtract_reg_reg,
                alu_pkg::subtract_reg_reg_branch,
                alu_pkg::multiply_reg_reg,
                alu_pkg::divide_reg_reg,
                alu_pkg::negate_reg_reg,
                alu_pkg::negate_reg_reg_branch: operand <= i_second;
                default: operand <= i_mem;
            endcase
            pc_v <= i_pc;
            ea_v <= i_ea;
            w2 <= i_word2;
            w3 <= i_word3;
            w4 <= i_word4;
            o_illegal <= ~encoding_ok;
        end
    end

    // ----------------------------------------------------------------
    // busy and done
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end
        else
        begin
            o_busy <= (state == st_idle) ? i_start : (state == st_run);
            o_done <= (state == st_run) && (count <= 12'h001);
        end
    end

    // ----------------------------------------------------------------
    // register file write-back
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_acc_we <= 1'b0;
            o_acc_addr <= 4'h0;
            o_acc_data <= 16'h0000;
            o_partner_we <= 1'b0;
            o_partner_addr <= 4'h0;
            o_partner_data <= 16'h0000;
        end
        else
        begin
            o_acc_we <= 1'b0;
            o_partner_we <= 1'b0;
            o_acc_addr <= acc_addr;
            o_partner_addr <= acc_addr | 4'h1;
            if (state == st_run && count <= 12'h001)
            begin
                case (alu_pkg::op_e'(op))
                    alu_pkg::subtract_short_displaced,
                    alu_pkg::subtract_short_indexed,
                    alu_pkg::subtract_reg_reg,
                    alu_pkg::subtract_reg_reg_branch:
                    begin
                        o_acc_we <= 1'b1;
                        o_acc_data <= diff;
                    end
                    alu_pkg::multiply_short_displaced,
                    alu_pkg::multiply_reg_reg:
                    begin
                        o_acc_we <= 1'b1;
                        if (acc_addr[0])
                            o_acc_data <= product[15:0];
                        else
                        begin
                            o_acc_data <= {product[31], product[30:16]};
                            o_partner_we <= 1'b1;
                            o_partner_data <= product[15:0];
                        end
                    end
                    alu_pkg::divide_short_indexed,
                    alu_pkg::divide_reg_reg:
                    begin
                        o_acc_we <= 1'b1;
                        o_acc_data <= div_rem;
                        o_partner_we <= 1'b1;
                        o_partner_data <= div_quot;
                    end
                    alu_pkg::move_and_clear_overflow:
                    begin
                        o_acc_we <= 1'b1;
                        o_acc_data <= {o_overflow, 14'h0000, o_carry_save};
                    end
                    alu_pkg::negate_reg_reg,
                    alu_pkg::negate_reg_reg_branch:
                    begin
                        o_acc_we <= 1'b1;
                        o_acc_data <= neg;
                    end
                    default: o_acc_we <= 1'b0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // program register selection
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_pc_we <= 1'b0;
            o_pc <= 16'h0000;
        end
        else
        begin
            o_pc_we <= 1'b0;
            if (state == st_run && count <= 12'h001)
            begin
                case (alu_pkg::op_e'(op))
                    alu_pkg::subtract_reg_reg_branch:
                    begin
                        o_pc_we <= 1'b1;
                        o_pc <= (diff != 16'h0000) ? ea_v : 16'(pc_v + alu_pkg::PC_STEP_2);
                    end
                    alu_pkg::negate_reg_reg_branch:
                    begin
                        o_pc_we <= 1'b1;
                        o_pc <= (neg != 16'h0000) ? ea_v : 16'(pc_v + alu_pkg::PC_STEP_2);
                    end
                    alu_pkg::compare_long_branch:
                    begin
                        o_pc_we <= 1'b1;
                        if (diff == 16'h0000)
                            o_pc <= w3;
                        else if (diff[15] ^ sub_ovf)
                            o_pc <= w4;
                        else
                            o_pc <= 16'(pc_v + alu_pkg::PC_STEP_4);
                    end
                    alu_pkg::compare_displaced_branch,
                    alu_pkg::compare_indexed_branch:
                    begin
                        o_pc_we <= 1'b1;
                        if (diff == 16'h0000)
                            o_pc <= w2;
                        else if (diff[15] ^ sub_ovf)
                            o_pc <= w3;
                        else
                            o_pc <= 16'(pc_v + alu_pkg::PC_STEP_3);
                    end
                    default: o_pc_we <= 1'b0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // overflow latch and carry save
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_overflow <= 1'b0;
            o_carry_save <= 1'b0;
        end
        else
        begin
            if (i_carry_valid)
                o_carry_save <= i_carry_in;
            if (state == st_run && count <= 12'h001)
            begin
                case (alu_pkg::op_e'(op))
                    alu_pkg::subtract_short_displaced,
                    alu_pkg::subtract_short_indexed,
                    alu_pkg::subtract_reg_reg,
                    alu_pkg::subtract_reg_reg_branch:
                    begin
                        if (sub_ovf)
                            o_overflow <= 1'b1;
                        o_carry_save <= ~diff_full[16];
                    end
                    alu_pkg::divide_short_indexed,
                    alu_pkg::divide_reg_reg:
                        if (div_ovf)
                            o_overflow <= 1'b1;
                    alu_pkg::negate_reg_reg,
                    alu_pkg::negate_reg_reg_branch:
                        if (operand == alu_pkg::MOST_NEGATIVE)
                            o_overflow <= 1'b1;
                    alu_pkg::move_and_clear_overflow: o_overflow <= 1'b0;
                    default: o_overflow <= o_overflow;
                endcase
            end
        end
    end
endmodule

// >>> test/alu_exec_chk.sv
// Purpose: port checks of the datapath
// Assumes: one clock, sync reset
// Notes: op code kept at each accepted start
`timescale 1ns/10ps
module alu_exec_chk
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_start,
    input wire logic [3:0] i_op,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_acc_we,
    input wire logic [15:0] o_acc_data,
    input wire logic o_partner_we,
    input wire logic [3:0] o_partner_addr,
    input wire logic o_pc_we,
    input wire logic o_overflow
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    logic [3:0] op_q;
    // op of the running instruction
    always_ff @(posedge i_clk)
    begin
        if (i_start && !o_busy)
            op_q <= i_op;
    end
    a_done_pulse: assert property (o_done |-> o_busy ##1 !o_done && !o_busy) else $error("done not one cycle");
    a_busy_start: assert property (i_start && !o_busy |=> o_busy) else $error("start not taken");
    a_pc_with_done: assert property (o_pc_we |-> o_done) else $error("pc write off done");
    a_partner_odd: assert property (o_partner_we |-> o_partner_addr[0]) else $error("partner even");
    a_mul_keeps_ovf: assert property (o_done && op_q inside {4'h4, 4'h5} |-> $stable(o_overflow))
        else $error("multiply moved overflow");
    a_cmp_no_write: assert property (o_done && op_q inside {4'h8, 4'h9, 4'ha} |->
        !o_acc_we && !o_partner_we && $stable(o_overflow)) else $error("compare wrote state");
    a_move_clears: assert property (o_done && op_q == 4'hb |-> !o_overflow && o_acc_data[14:1] == 14'h0
        && o_acc_data[15] == $past(o_overflow)) else $error("move result wrong");
    a_neg_min: assert property (o_done && op_q inside {4'hc, 4'hd} && o_acc_data == 16'h8000 |-> o_overflow)
        else $error("negate overflow missing");
    c_branch: cover property (o_done && o_pc_we);
    c_ovf: cover property (o_done && o_overflow);
    c_pair: cover property (o_partner_we);
endmodule
bind alu_exec alu_exec_chk u_chk (.i_clk, .i_srst, .i_start, .i_op, .o_busy, .o_done, .o_acc_we, .o_acc_data,
    .o_partner_we, .o_partner_addr, .o_pc_we, .o_overflow);

// >>> test/reg_file_model.sv
// Purpose: general register file beside the datapath
// Assumes: writes land on the clock edge
// Notes: unwritten registers read unknown
`timescale 1ns/10ps
module reg_file_model
(
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_data,
    input wire logic [3:0] i_rd_addr,
    output logic [15:0] o_rd_data
);
    logic [15:0] regs [16];
    // accumulator write port
    always_ff @(posedge i_clk)
    begin
        if (i_we)
            regs[i_addr] <= i_data;
    end
    assign o_rd_data = regs[i_rd_addr];
endmodule

// >>> test/test_subtract_muldiv_compare_alu.sv
// Purpose: scenario bench of the datapath
// Assumes: CLK_NS set to 100, so counts are tenths
// Notes: inputs change at the falling edge
`timescale 1ns/10ps
module test_subtract_muldiv_compare_alu;
    logic i_clk, i_srst, i_start, i_carry_in, i_carry_valid;
    logic [3:0] i_op, ra;
    logic [15:0] i_instr, i_acc, i_partner, i_second, i_mem, rd;
    logic [15:0] i_pc = 16'h0100, i_ea = 16'h0200, i_word2 = 16'h0302, i_word3 = 16'h0303, i_word4 = 16'h0304;
    logic o_busy, o_done, o_acc_we, o_partner_we, o_pc_we, o_overflow, o_carry_save, o_illegal;
    logic [3:0] o_acc_addr, o_partner_addr;
    logic [15:0] o_acc_data, o_partner_data, o_pc;
    int n_fail = 0, comparisons = 0, cyc = 0;
    alu_exec #(.CLK_NS(100)) dut_u (.i_clk, .i_srst, .i_start, .i_op, .i_instr, .i_acc, .i_partner, .i_second,
        .i_mem, .i_pc, .i_ea, .i_word2, .i_word3, .i_word4, .i_carry_in, .i_carry_valid, .o_busy, .o_done,
        .o_acc_we, .o_acc_addr, .o_acc_data, .o_partner_we, .o_partner_addr, .o_partner_data, .o_pc_we, .o_pc,
        .o_overflow, .o_carry_save, .o_illegal);
    reg_file_model rf_u (.i_clk, .i_we(o_acc_we), .i_addr(o_acc_addr), .i_data(o_acc_data), .i_rd_addr(ra),
        .o_rd_data(rd));
    // clock and hang guard
    initial
    begin
        i_clk = 0;
        forever #5 i_clk = ~i_clk;
    end
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one instruction, judged on its length in cycles
    task automatic run(input logic [3:0] op, input logic [15:0] ins, a, p, b, m, input int n);
        int k;
        @(negedge i_clk);
        {i_op, i_instr, i_acc, i_partner, i_second, i_mem, i_start} = {op, ins, a, p, b, m, 1'b1};
        @(negedge i_clk);
        i_start = 0;
        k = 0;
        while (o_done !== 1'b1 && k < 2000)
        begin
            @(negedge i_clk);
            k++;
        end
        chk(16'(k), 16'(n));
    endtask
    task automatic t_sub();
        run(4'h2, 16'h6935, 16'h8000, 0, 16'h0001, 0, 8);
        chk(o_overflow, 1);
        chk(o_illegal, 16'h0000);
        ra = 4'h3;
        @(negedge i_clk);
        chk(rd, 16'h7fff);
        run(4'h1, 16'hf940, 16'h0005, 0, 0, 16'h0007, 19);
        chk(o_acc_data, 16'hfffe);
        run(4'h0, 16'h0050, 16'h0010, 0, 0, 16'h0001, 19);
        chk(o_acc_data, 16'h000f);
        run(4'hb, 16'h0040, 0, 0, 0, 0, 8);
        chk(o_acc_data, 16'h8001);
        run(4'h3, 16'h0035, 16'h0005, 0, 16'h0005, 0, 16);
        chk(o_pc, 16'h0102);
        run(4'h3, 16'h0035, 16'h0006, 0, 16'h0005, 0, 16);
        chk(o_pc, 16'h0200);
    endtask
    task automatic t_muldiv();
        run(4'h5, 16'h2027, 16'h1234, 16'hfffd, 16'h0007, 0, 67);
        chk({o_acc_data, o_partner_data} >> 16, 16'hffff);
        chk(o_partner_data, 16'hffeb);
        chk(o_partner_addr, 16'h3);
        run(4'h4, 16'hb050, 0, 16'hfffd, 0, 16'h0007, 73);
        chk({o_acc_data[15:1], o_partner_we}, 16'hffea);
        run(4'h7, 16'h0027, 0, 16'h0064, 16'h0007, 0, 110);
        chk(o_partner_data, 16'h000e);
        chk({o_acc_data[7:0], 7'h0, o_overflow}, 16'h0200);
        run(4'h6, 16'hb920, 16'hffff, 16'hff9c, 0, 16'h0007, 114);
        chk(o_partner_data & 16'h8000, 16'h8000);
        run(4'h7, 16'h0027, 16'h4000, 0, 16'h0002, 0, 110);
        chk(o_overflow, 1);
        run(4'hb, 16'h0040, 0, 0, 0, 0, 8);
        run(4'h7, 16'h0027, 16'h0001, 0, 16'h0002, 0, 110);
        chk(o_overflow, 1);
        run(4'hb, 16'h0040, 0, 0, 0, 0, 8);
    endtask
    task automatic t_cmp();
        logic [15:0] pcs [9] = '{16'h0304, 16'h0303, 16'h0104, 16'h0303, 16'h0302, 16'h0103,
            16'h0303, 16'h0302, 16'h0103};
        for (int i = 0; i < 9; i++)
        begin
            run(4'h8 + 4'(i / 3), 16'hc710, 16'h0002 + 16'(i % 3), 0, 0, 16'h0003, i < 3 ? 46 : 40);
            chk(o_pc, pcs[i]);
            chk(o_acc_we, 0);
        end
    endtask
    task automatic t_neg();
        run(4'hc, 16'h0061, 0, 0, 16'h8000, 0, 8);
        chk(o_acc_data, 16'h8000);
        chk(o_overflow, 16'h0001);
        run(4'hd, 16'h0061, 0, 0, 0, 0, 16);
        chk(o_pc, 16'h0102);
        run(4'hd, 16'h0061, 0, 0, 16'h0005, 0, 16);
        chk(o_pc, 16'h0200);
        chk(o_acc_data, 16'hfffb);
    endtask
    initial
    begin
        {i_srst, i_start, i_carry_in, i_carry_valid, i_op, ra} = {1'b1, 11'h0};
        {i_instr, i_acc, i_partner, i_second, i_mem} = '0;
        repeat (6) @(negedge i_clk);
        i_srst = 0;
        chk({o_busy, o_done, o_acc_we, o_pc_we, o_overflow}, 0);
        t_sub();
        t_muldiv();
        t_cmp();
        t_neg();
        give_verdict();
    end
endmodule
